// file: design/lml_top.sv
`timescale 1ns/1ps
`default_nettype none
module lml_top #(
    parameter int DOTS = lml_pkg::DOTS_PER_IC
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [4:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [4:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        link_clk,
    input  wire logic        serial_in,
    input  wire logic        load_window_n,
    input  wire logic        dest_select,
    input  wire logic        reset_pin_n,
    output logic             serial_out,
    output logic [2*DOTS-1:0] led_drive,
    output logic [1:0]       awake
);
    localparam int CH = 2 * DOTS;

    // ---------------------------------------------------------------
    // Pin synchronisers and edge detection
    // ---------------------------------------------------------------
    lml_pkg::lml_pins_t pin_in, s1_r, s2_r, prev_r;
    assign pin_in = '{link_clk, serial_in, load_window_n,
                      dest_select, reset_pin_n};

    // Two flops per pin, then a third stage for edges.
    always_ff @(posedge aclk) begin
        s1_r   <= pin_in;
        s2_r   <= s1_r;
        prev_r <= s2_r;
    end

    logic clk_rise, win_fall, win_rise, clr;
    assign clk_rise = s2_r.link_clk && !prev_r.link_clk;
    assign win_fall = !s2_r.load_window_n && prev_r.load_window_n;
    assign win_rise = s2_r.load_window_n && !prev_r.load_window_n;
    assign clr      = !aresetn || !s2_r.reset_n;

    // ---------------------------------------------------------------
    // Load window sequencer
    // ---------------------------------------------------------------
    lml_pkg::lml_state_t st_r, st_nxt;
    logic               sel_r, sel_nxt;
    lml_pkg::lml_evt_t  evt;

    // Tracks window open, closed-awaiting-low-clock, and idle.
    always_comb begin
        st_nxt  = st_r;
        sel_nxt = sel_r;
        case (st_r)
            lml_pkg::ST_IDLE, lml_pkg::ST_PEND: begin
                if (win_fall) begin
                    st_nxt  = lml_pkg::ST_SHIFT;
                    sel_nxt = s2_r.dest_select;
                end else if (st_r == lml_pkg::ST_PEND &&
                             !s2_r.link_clk) begin
                    st_nxt = lml_pkg::ST_IDLE;
                end
            end
            lml_pkg::ST_SHIFT: begin
                if (win_rise) begin
                    st_nxt = lml_pkg::ST_PEND;
                end
            end
            default: begin
                st_nxt = lml_pkg::ST_IDLE;
            end
        endcase
        if (!aresetn) begin
            st_nxt  = lml_pkg::ST_IDLE;
            sel_nxt = 1'b0;
        end
    end

    // Sequencer registers.
    always_ff @(posedge aclk) begin
        st_r  <= st_nxt;
        sel_r <= sel_nxt;
    end

    // Shift on each link clock rise inside the window.
    assign evt.shift_en = st_r == lml_pkg::ST_SHIFT && clk_rise &&
                          !s2_r.load_window_n;
    assign evt.sel_ctrl = sel_r;
    assign evt.commit   = st_r == lml_pkg::ST_PEND && !win_fall &&
                          s2_r.load_window_n && !s2_r.link_clk;

    // ---------------------------------------------------------------
    // Two cascaded driver ICs
    // ---------------------------------------------------------------
    logic            d0, d1;
    logic [7:0]      csh0, csh1;
    logic [6:0]      cw0_0, cw1_0, cw0_1, cw1_1;
    logic [DOTS-1:0] sh0, sh1, lat0, lat1;

    lml_ic #(.DOTS(DOTS)) u_ic0 (
        .aclk    (aclk),
        .clr     (clr),
        .evt     (evt),
        .din     (s2_r.serial_in),
        .dout    (d0),
        .csh     (csh0),
        .cw0     (cw0_0),
        .cw1     (cw1_0),
        .dot_sh  (sh0),
        .dot_lat (lat0)
    );

    // The second IC is fed by the first one's output.
    lml_ic #(.DOTS(DOTS)) u_ic1 (
        .aclk    (aclk),
        .clr     (clr),
        .evt     (evt),
        .din     (d0),
        .dout    (d1),
        .csh     (csh1),
        .cw0     (cw0_1),
        .cw1     (cw1_1),
        .dot_sh  (sh1),
        .dot_lat (lat1)
    );

    logic [CH-1:0] lat_all;
    assign lat_all = {lat1, lat0};

    // ---------------------------------------------------------------
    // Register file over AXI4-Lite
    // ---------------------------------------------------------------
    logic        awv_r, awv_nxt, wv_r, wv_nxt;
    logic [4:0]  awa_r, awa_nxt;
    logic [31:0] wd_r, wd_nxt;
    logic        wb0_r, wb0_nxt;
    logic        bv_r, bv_nxt, rv_r, rv_nxt;
    logic [1:0]  br_r, br_nxt, rr_r, rr_nxt;
    logic [31:0] rd_r, rd_nxt;
    logic        awr_r, awr_nxt, wr_r, wr_nxt, arr_r, arr_nxt;
    logic        blank_r, blank_nxt;
    logic [3:0]  dsel_r, dsel_nxt;
    logic [31:0] dot_word;

    // Selected 32-bit slice of the shown dot latches.
    always_comb begin
        dot_word = 32'h0000_0000;
        if (int'(dsel_r) < lml_pkg::DOT_WORDS) begin
            dot_word = lat_all[int'(dsel_r)*32 +: 32];
        end
    end

    // Write channels taken in any order, read answered alone.
    always_comb begin
        awv_nxt = awv_r;
        awa_nxt = awa_r;
        wv_nxt  = wv_r;
        wd_nxt  = wd_r;
        wb0_nxt = wb0_r;
        bv_nxt  = bv_r;
        br_nxt  = br_r;
        rv_nxt  = rv_r;
        rr_nxt  = rr_r;
        rd_nxt  = rd_r;
        blank_nxt = blank_r;
        dsel_nxt  = dsel_r;
        if (s_axi_awvalid && awr_r) begin
            awv_nxt = 1'b1;
            awa_nxt = s_axi_awaddr;
        end
        if (s_axi_wvalid && wr_r) begin
            wv_nxt  = 1'b1;
            wd_nxt  = s_axi_wdata;
            wb0_nxt = s_axi_wstrb[0];
        end
        if (bv_r && s_axi_bready) begin
            bv_nxt = 1'b0;
        end
        if (awv_r && wv_r && !bv_r) begin
            awv_nxt = 1'b0;
            wv_nxt  = 1'b0;
            bv_nxt  = 1'b1;
            br_nxt  = lml_pkg::RESP_OK;
            if (awa_r == lml_pkg::CFG_OFS) begin
                if (wb0_r) blank_nxt = wd_r[0];
            end else if (awa_r == lml_pkg::DSEL_OFS) begin
                if (wb0_r) dsel_nxt = wd_r[3:0];
            end else if (awa_r != lml_pkg::CW_OFS &&
                         awa_r != lml_pkg::DDAT_OFS &&
                         awa_r != lml_pkg::STAT_OFS) begin
                br_nxt = lml_pkg::RESP_DEC;
            end
        end
        if (rv_r && s_axi_rready) begin
            rv_nxt = 1'b0;
        end
        if (s_axi_arvalid && arr_r) begin
            rv_nxt = 1'b1;
            rr_nxt = lml_pkg::RESP_OK;
            if (s_axi_araddr == lml_pkg::CFG_OFS) begin
                rd_nxt = {31'h0, blank_r};
            end else if (s_axi_araddr == lml_pkg::CW_OFS) begin
                rd_nxt = {1'b0, cw1_1, 1'b0, cw0_1,
                          1'b0, cw1_0, 1'b0, cw0_0};
            end else if (s_axi_araddr == lml_pkg::DSEL_OFS) begin
                rd_nxt = {28'h0, dsel_r};
            end else if (s_axi_araddr == lml_pkg::DDAT_OFS) begin
                rd_nxt = dot_word;
            end else if (s_axi_araddr == lml_pkg::STAT_OFS) begin
                rd_nxt = {27'h0, awake, sel_r, st_r};
            end else begin
                rd_nxt = 32'h0000_0000;
                rr_nxt = lml_pkg::RESP_DEC;
            end
        end
        awr_nxt = !awv_nxt && !bv_nxt;
        wr_nxt  = !wv_nxt && !bv_nxt;
        arr_nxt = !rv_nxt;
        if (!aresetn) begin
            awv_nxt = 1'b0;
            wv_nxt  = 1'b0;
            bv_nxt  = 1'b0;
            rv_nxt  = 1'b0;
            awr_nxt = 1'b0;
            wr_nxt  = 1'b0;
            arr_nxt = 1'b0;
            br_nxt  = lml_pkg::RESP_OK;
            rr_nxt  = lml_pkg::RESP_OK;
            rd_nxt  = 32'h0000_0000;
            blank_nxt = lml_pkg::BLANK_RST;
            dsel_nxt  = lml_pkg::DSEL_RST;
        end
    end

    // Bus registers.
    always_ff @(posedge aclk) begin
        awv_r <= awv_nxt;
        awa_r <= awa_nxt;
        wv_r  <= wv_nxt;
        wd_r  <= wd_nxt;
        wb0_r <= wb0_nxt;
        bv_r  <= bv_nxt;
        br_r  <= br_nxt;
        rv_r  <= rv_nxt;
        rr_r  <= rr_nxt;
        rd_r  <= rd_nxt;
        awr_r <= awr_nxt;
        wr_r  <= wr_nxt;
        arr_r <= arr_nxt;
        blank_r <= blank_nxt;
        dsel_r  <= dsel_nxt;
    end

    assign s_axi_awready = awr_r;
    assign s_axi_wready  = wr_r;
    assign s_axi_bvalid  = bv_r;
    assign s_axi_bresp   = br_r;
    assign s_axi_arready = arr_r;
    assign s_axi_rvalid  = rv_r;
    assign s_axi_rresp   = rr_r;
    assign s_axi_rdata   = rd_r;

    // ---------------------------------------------------------------
    // LED drive and serial output
    // ---------------------------------------------------------------
    logic [CH-1:0] led_nxt;
    logic [1:0]    awake_nxt;
    logic          sout_nxt;

    // Lit when latched high, on a real row, awake and unblanked.
    always_comb begin
        awake_nxt = {cw0_1[lml_pkg::CW0_WAKE], cw0_0[lml_pkg::CW0_WAKE]};
        sout_nxt  = d1;
        for (int j = 0; j < CH; j++) begin
            led_nxt[j] = lat_all[j] && (j % lml_pkg::ROWS != 0) &&
                         awake_nxt[j / DOTS] && !blank_r;
        end
    end

    // Output registers; no reset term, but dots go dark once reset clears wake.
    always_ff @(posedge aclk) begin
        led_drive  <= led_nxt;
        awake      <= awake_nxt;
        serial_out <= sout_nxt;
    end

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence dot_commit_s;
        evt.commit && !sel_r;
    endsequence

    sequence ctrl_commit_s;
        evt.commit && sel_r;
    endsequence

    ctrl_reset_a: assert property (!s2_r.reset_n |=> ##1
        cw0_0 == 7'h00 && cw0_1 == 7'h00 && awake == 2'h0)
        else $error("control words not cleared by reset pin");
    dot_keep_a: assert property (!evt.commit |=>
        $stable(lat_all)) else $error("dot latch changed without copy");
    dot_shift_a: assert property (evt.shift_en && !sel_r |=>
        sh0[0] == $past(s2_r.serial_in))
        else $error("dot shift missed serial_in");
    chain_link_a: assert property (evt.shift_en && !sel_r |=>
        sh1[0] === $past(sh0[DOTS-1]))
        else $error("second IC missed overflow bit");
    dot_copy_a: assert property (dot_commit_s |=>
        lat_all == $past({sh1, sh0})) else $error("dot copy wrong");
    cw_pick_a: assert property (ctrl_commit_s ##0 !csh0[7] |=>
        cw0_0 == $past(csh0[6:0]) && $stable(cw1_0))
        else $error("control word 0 load wrong");
    ctrl_shift_a: assert property (evt.shift_en && sel_r |=>
        csh0 == {$past(csh0[6:0]), $past(s2_r.serial_in)})
        else $error("control shift wrong");
    sel_sample_a: assert property (win_fall && st_r != lml_pkg::ST_SHIFT
        |=> sel_r == $past(s2_r.dest_select))
        else $error("select not sampled at window fall");
    led_map_a: assert property ($past(lat_all[1] && awake_nxt[0] &&
        !blank_r) |-> led_drive[1] && !led_drive[0])
        else $error("pixel mapping wrong");
    sleep_dark_a: assert property (!cw0_0[lml_pkg::CW0_WAKE] |=>
        led_drive[DOTS-1:0] == '0 && !awake[0])
        else $error("sleeping IC drives LEDs");
    simul_out_a: assert property (sel_r && cw1_0[0] && cw1_1[0] |=>
        serial_out == $past(s2_r.serial_in))
        else $error("simultaneous output not following input");
endmodule
`default_nettype wire

// file: design/lml_pkg.sv
// Operation
// - Each IC holds a 160-bit dot shift register.
// - Each IC holds two 7-bit control words.
// - Two ICs chain into one 320-bit register.
// - Reset clears control words, display sleeps.
// - Reset never clears the dot register.
// - Rising clock in window shifts serial_in.
// - Dot one lights LED, zero leaves dark.
// - Window high, clock low copies dots.
// - Twenty columns of eight, row 0 unlit.
// - Locations 0-7 form leftmost column.
// - Control shifts MSB first, bit 7 picks.
// - Unpicked control word keeps its value.
// - Control word loads on window rise, clock low.
// - Select sampled at window falling edge.
// - Reset pin is active low.
// - Output follows mode during control writes.
// - Word 0 bit 6 low puts IC asleep.
package lml_pkg;
    localparam int DOTS_PER_IC = 160;
    localparam int NUM_IC      = 2;
    localparam int CW_W        = 7;
    localparam int CSH_W       = 8;
    localparam int ROWS        = 8;
    localparam int COLS        = 20;
    localparam int CW_SEL_BIT  = 7;
    localparam int CW0_WAKE    = 6;
    localparam int CW1_SIMUL   = 0;
    localparam int AXI_AW      = 5;
    localparam int DOT_WORDS   = 10;

    localparam logic [4:0] CFG_OFS  = 5'h00;
    localparam logic [4:0] CW_OFS   = 5'h04;
    localparam logic [4:0] DSEL_OFS = 5'h08;
    localparam logic [4:0] DDAT_OFS = 5'h0C;
    localparam logic [4:0] STAT_OFS = 5'h10;

    localparam logic [6:0] CW_RST   = 7'h00;
    localparam logic [7:0] CSH_RST  = 8'h00;
    localparam logic       BLANK_RST = 1'b0;
    localparam logic [3:0] DSEL_RST = 4'h0;
    localparam logic [1:0] RESP_OK  = 2'h0;
    localparam logic [1:0] RESP_DEC = 2'h3;

    typedef struct packed {
        logic link_clk;
        logic serial_in;
        logic load_window_n;
        logic dest_select;
        logic reset_n;
    } lml_pins_t;

    typedef struct packed {
        logic shift_en;
        logic sel_ctrl;
        logic commit;
    } lml_evt_t;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'h0,
        ST_SHIFT = 2'h1,
        ST_PEND  = 2'h3
    } lml_state_t;
endpackage

// file: design/lml_ic.sv
`timescale 1ns/1ps
`default_nettype none
module lml_ic #(
    parameter int DOTS = lml_pkg::DOTS_PER_IC
) (
    input  wire logic              aclk,
    input  wire logic              clr,
    input  wire lml_pkg::lml_evt_t evt,
    input  wire logic              din,
    output logic                   dout,
    output logic [7:0]             csh,
    output logic [6:0]             cw0,
    output logic [6:0]             cw1,
    output logic [DOTS-1:0]        dot_sh,
    output logic [DOTS-1:0]        dot_lat
);
    logic [DOTS-1:0] sh_r, sh_nxt, lat_r, lat_nxt;
    logic [7:0]      csh_r, csh_nxt;
    logic [6:0]      cw0_r, cw0_nxt, cw1_r, cw1_nxt;

    // ---------------------------------------------------------------
    // Dot path
    // ---------------------------------------------------------------
    // Dot shift and latch; neither is touched by any reset.
    always_comb begin
        sh_nxt  = sh_r;
        lat_nxt = lat_r;
        if (evt.shift_en && !evt.sel_ctrl) begin
            sh_nxt = {sh_r[DOTS-2:0], din};
        end
        if (evt.commit && !evt.sel_ctrl) begin
            lat_nxt = sh_r;
        end
    end

    // Dot storage has no reset term.
    always_ff @(posedge aclk) begin
        sh_r  <= sh_nxt;
        lat_r <= lat_nxt;
    end

    // ---------------------------------------------------------------
    // Control path
    // ---------------------------------------------------------------
    // Control shift register and the two control words.
    always_comb begin
        csh_nxt = csh_r;
        cw0_nxt = cw0_r;
        cw1_nxt = cw1_r;
        if (evt.shift_en && evt.sel_ctrl) begin
            csh_nxt = {csh_r[6:0], din};
        end
        if (evt.commit && evt.sel_ctrl) begin
            if (csh_r[lml_pkg::CW_SEL_BIT]) begin
                cw1_nxt = csh_r[6:0];
            end else begin
                cw0_nxt = csh_r[6:0];
            end
        end
        if (clr) begin
            csh_nxt = lml_pkg::CSH_RST;
            cw0_nxt = lml_pkg::CW_RST;
            cw1_nxt = lml_pkg::CW_RST;
        end
    end

    // Control state registers.
    always_ff @(posedge aclk) begin
        csh_r <= csh_nxt;
        cw0_r <= cw0_nxt;
        cw1_r <= cw1_nxt;
    end

    // Serial output select: overflow of the chosen register, or din in simultaneous control mode.
    always_comb begin
        if (evt.sel_ctrl) begin
            dout = cw1_r[lml_pkg::CW1_SIMUL] ? din : csh_r[7];
        end else begin
            dout = sh_r[DOTS-1];
        end
    end

    assign csh     = csh_r;
    assign cw0     = cw0_r;
    assign cw1     = cw1_r;
    assign dot_sh  = sh_r;
    assign dot_lat = lat_r;
endmodule
`default_nettype wire

// file: tb/lml_host.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Host model of the serial load port
// ----------------------------------------------------------------
// The link clock stands low outside frames and runs at 80 ns per bit.
module lml_host (
    input  wire logic aclk,
    output logic      link_clk,
    output logic      serial_in,
    output logic      load_window_n,
    output logic      dest_select
);
    logic busy;

    // All pins start idle: window closed, clock low.
    initial begin
        busy = 1'b0;
        link_clk = 1'b0;
        serial_in = 1'b0;
        load_window_n = 1'b1;
        dest_select = 1'b0;
    end

    // Outside a frame the data line is not held, so it keeps changing.
    always @(posedge aclk) begin
        if (!busy) begin
            serial_in <= ~serial_in;
        end
    end

    // One frame: select, open window, shift n bits MSB first, close.
    task automatic frame(input logic [319:0] v, input int n, input logic sel);
        @(posedge aclk);
        busy <= 1'b1;
        dest_select <= sel;
        repeat (5) @(posedge aclk);
        load_window_n <= 1'b0;
        repeat (5) @(posedge aclk);
        for (int i = n - 1; i >= 0; i--) begin
            serial_in <= v[i];
            repeat (5) @(posedge aclk);
            link_clk <= 1'b1;
            repeat (5) @(posedge aclk);
            link_clk <= 1'b0;
        end
        repeat (5) @(posedge aclk);
        load_window_n <= 1'b1;
        repeat (10) @(posedge aclk);
        dest_select <= ~sel;
        busy <= 1'b0;
    endtask

    // A full 320-bit dot load through both chained ICs.
    task automatic load_dots(input logic [319:0] v);
        frame(v, 320, 1'b0);
    endtask

    // Two control bytes for the chained pair in serial mode.
    task automatic load_ctrl2(input logic [15:0] v);
        frame({304'h0, v}, 16, 1'b1);
    endtask

    // One control byte reaching both ICs in simultaneous mode.
    task automatic load_ctrl1(input logic [7:0] v);
        frame({312'h0, v}, 8, 1'b1);
    endtask
endmodule
`default_nettype wire

// file: tb/led_matrix_serial_loader_test.sv
`timescale 1ns/1ps
`default_nettype none
module led_matrix_serial_loader_test;
    logic         aclk, aresetn, reset_pin_n, serial_out;
    logic [4:0]   awaddr, araddr;
    logic         awvalid, wvalid, bready, arvalid, rready;
    logic         awready, wready, bvalid, arready, rvalid;
    logic [31:0]  wdata, rdata, got;
    logic [3:0]   wstrb;
    logic [1:0]   bresp, rresp, awake, rsp;
    logic [319:0] led;
    logic         link_clk, serial_in, load_window_n, dest_select;
    int           err_total, num_checks;
    localparam logic [319:0] PA = {5{64'h0123456789ABCDEF}};
    localparam logic [319:0] PB = {10{32'h5A3C96E1}};
    localparam logic [1:0]   OK = lml_pkg::RESP_OK;
    localparam logic [1:0]   DEC = lml_pkg::RESP_DEC;

    lml_top DUT (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .link_clk(link_clk), .serial_in(serial_in),
        .load_window_n(load_window_n), .dest_select(dest_select),
        .reset_pin_n(reset_pin_n), .serial_out(serial_out),
        .led_drive(led), .awake(awake));

    lml_host host (.aclk(aclk), .link_clk(link_clk), .serial_in(serial_in),
        .load_window_n(load_window_n), .dest_select(dest_select));

    // ----------------------------------------------------------------
    // Clock, compare and bus tasks
    // ----------------------------------------------------------------
    // The clock toggles every 4 ns for a 125 MHz rate.
    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end

    // Compares one 32-bit result.
    task automatic chk_w(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    // Compares the whole LED drive vector.
    task automatic chk_led(input logic [319:0] e);
        num_checks++;
        if (led !== e) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, led, e);
        end
    endtask

    // Masks row 0 of every column, which has no LED.
    function automatic logic [319:0] lit(input logic [319:0] v);
        lit = v;
        for (int j = 0; j < 320; j += 8) begin
            lit[j] = 1'b0;
        end
    endfunction

    // Write: both channels offered, each released when taken.
    task automatic wr_chk(input logic [4:0] a, input logic [31:0] d,
                          input logic [1:0] er);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        chk_w({30'h0, bresp}, {30'h0, er});
    endtask

    // Read: address released when taken, data taken with rvalid.
    task automatic rd_chk(input logic [4:0] a, input logic [31:0] e,
                          input logic [1:0] er);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
        got = rdata;
        rsp = rresp;
        chk_w(got, e);
        chk_w({30'h0, rsp}, {30'h0, er});
    endtask

    task automatic end_test(input string s);
        $display("test %s finished, errors so far %0d", s, err_total);
    endtask

    task automatic give_verdict;
        $display("checks %0d, mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Watchdog well beyond the roughly 14000 cycles the tests need.
    initial begin
        repeat (80000) @(posedge aclk);
        err_total++;
        give_verdict();
    end

    // ----------------------------------------------------------------
    // Test sequence
    // ----------------------------------------------------------------
    // Resets, wakes, loads dots and exercises control words.
    initial begin
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        awaddr = 5'h00;
        araddr = 5'h00;
        wdata = 32'h0;
        wstrb = 4'hF;
        aresetn = 1'b0;
        reset_pin_n = 1'b1;
        err_total = 0;
        num_checks = 0;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        chk_w({30'h0, awake}, 32'h0);
        chk_led('0);
        rd_chk(lml_pkg::CW_OFS, 32'h0, OK);
        rd_chk(5'h14, 32'h0, DEC);
        end_test("reset");
        host.load_dots('0);
        host.load_ctrl2(16'h4F4F);
        chk_w({30'h0, awake}, 32'h3);
        rd_chk(lml_pkg::CW_OFS, 32'h004F004F, OK);
        chk_led('0);
        end_test("wake");
        host.load_dots(PA);
        chk_led(lit(PA));
        chk_w({31'h0, serial_out}, {31'h0, PA[319]});
        wr_chk(lml_pkg::DSEL_OFS, 32'h9, OK);
        rd_chk(lml_pkg::DDAT_OFS, PA[319:288], OK);
        wr_chk(lml_pkg::DSEL_OFS, 32'hA, OK);
        rd_chk(lml_pkg::DDAT_OFS, 32'h0, OK);
        wr_chk(5'h18, 32'h1, DEC);
        end_test("dots");
        fork
            host.load_dots(PB);
            begin
                repeat (1600) @(posedge aclk);
                chk_led(lit(PA));
            end
        join
        chk_led(lit(PB));
        end_test("reload");
        host.load_ctrl2(16'h8181);
        rd_chk(lml_pkg::CW_OFS, 32'h014F014F, OK);
        chk_w({30'h0, awake}, 32'h3);
        host.load_ctrl1(8'h0F);
        rd_chk(lml_pkg::CW_OFS, 32'h010F010F, OK);
        chk_w({30'h0, awake}, 32'h0);
        chk_led('0);
        host.load_ctrl1(8'h4F);
        chk_led(lit(PB));
        end_test("control");
        wstrb <= 4'hE;
        wr_chk(lml_pkg::CFG_OFS, 32'h1, OK);
        wstrb <= 4'hF;
        rd_chk(lml_pkg::CFG_OFS, 32'h0, OK);
        wr_chk(lml_pkg::CFG_OFS, 32'h1, OK);
        repeat (4) @(posedge aclk);
        chk_led('0);
        rd_chk(lml_pkg::CFG_OFS, 32'h1, OK);
        wr_chk(lml_pkg::CFG_OFS, 32'h0, OK);
        repeat (4) @(posedge aclk);
        chk_led(lit(PB));
        end_test("blank");
        reset_pin_n <= 1'b0;
        repeat (8) @(posedge aclk);
        reset_pin_n <= 1'b1;
        repeat (8) @(posedge aclk);
        chk_w({30'h0, awake}, 32'h0);
        chk_led('0);
        rd_chk(lml_pkg::CW_OFS, 32'h0, OK);
        wr_chk(lml_pkg::DSEL_OFS, 32'h0, OK);
        rd_chk(lml_pkg::DDAT_OFS, PB[31:0], OK);
        host.load_ctrl2(16'h4F4F);
        chk_led(lit(PB));
        end_test("pin reset");
        host.load_dots(~PB);
        chk_led(lit(~PB));
        chk_w({31'h0, serial_out}, 32'h1);
        wr_chk(lml_pkg::DSEL_OFS, 32'h5, OK);
        aresetn <= 1'b0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        chk_w({30'h0, awake}, 32'h0);
        chk_led('0);
        rd_chk(lml_pkg::DSEL_OFS, 32'h0, OK);
        rd_chk(lml_pkg::DDAT_OFS, ~PB[31:0], OK);
        end_test("bus reset");
        give_verdict();
    end
endmodule
`default_nettype wire
